/* logic/rsp_pkg.sv */
// Purpose: Shared constants for strap capture and RMII pin roles.
// Assumes: Single 32-bit AXI4-Lite register window, word aligned.
// Notes: Strap vector and link control vector layouts live here.
`default_nettype none
package rsp_pkg;
	// Synchronised pin vector layout
	localparam int RSP_NPIN = 8;
	localparam int RSP_S_A0 = 0;
	localparam int RSP_S_A1 = 1;
	localparam int RSP_S_A2 = 2;
	localparam int RSP_S_DUP = 3;
	localparam int RSP_S_CFG2 = 4;
	localparam int RSP_S_BCAST = 5;
	localparam int RSP_S_ISO = 6;
	localparam int RSP_S_IRQ = 7;
	localparam int RSP_NSTRAP = 7;
	// Register byte offsets
	localparam logic [7:0] RSP_OFF_CTRL = 8'h00;
	localparam logic [7:0] RSP_OFF_STRAP = 8'h04;
	localparam logic [7:0] RSP_OFF_CLK = 8'h08;
	localparam logic [7:0] RSP_OFF_STAT = 8'h0C;
	// Control register fields and reset values
	localparam int RSP_CTRL_DUP = 8;
	localparam int RSP_CTRL_ISO = 10;
	localparam logic [15:0] RSP_CTRL_WMASK = 16'h0500;
	localparam logic [15:0] RSP_CTRL_RST = 16'h0000;
	localparam logic RSP_MODE25_RST = 1'b1;
	localparam int RSP_STRAP_DONE = 8;
	localparam logic [1:0] RSP_RESP_OKAY = 2'h0;
	localparam logic [1:0] RSP_RESP_SLVERR = 2'h2;
	// Core to link control vector layout
	localparam int RSP_LNK_W = 4;
	localparam int RSP_L_RST = 0;
	localparam int RSP_L_DRV = 1;
	localparam int RSP_L_M25 = 2;
	localparam int RSP_L_ISO = 3;
endpackage : rsp_pkg
`default_nettype wire

/* logic/rsp_link_if.sv */
// Purpose: Carries control levels between the register domain and the link domain.
// Assumes: Every signal is a slow level; the receiver synchronises it.
// Notes: No clocking block; both sides own a clock of their own.
`default_nettype none
interface rsp_link_if import rsp_pkg::*; ();
	logic [RSP_LNK_W-1:0] ctl;
	logic link_alive;
	modport core (output ctl, input link_alive);
	modport link (input ctl, output link_alive);
endinterface : rsp_link_if
`default_nettype wire

/* logic/rsp_sync3.sv */
// Purpose: Three-stage synchroniser with agreement filter per bit.
// Assumes: Inputs are levels from another clock or from pins.
// Notes: Output changes only once stages two and three agree.
`default_nettype none
module rsp_sync3 #(parameter int W = 1) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1_reg;
			logic s2_reg;
			logic s3_reg;
			logic q_reg;
			// Not reset: the chain must keep tracking pins while reset is held
			always_ff @(posedge clk) begin
				s1_reg <= d[i];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				if (s2_reg == s3_reg) begin
					q_reg <= s3_reg;
				end
			end
			assign q[i] = q_reg;
		end
	endgenerate
endmodule : rsp_sync3
`default_nettype wire

/* logic/rsp_link.sv */
// Purpose: RMII receive-side pin drivers and reference clock output.
// Assumes: rmii_clk is the internally derived 50 MHz RMII clock.
// Notes: Pins stay released until the core domain reports straps captured.
`default_nettype none
module rsp_link import rsp_pkg::*; (
	input wire logic rmii_clk,
	rsp_link_if.link lif,
	input wire logic [1:0] core_rxd,
	input wire logic core_crs_dv,
	input wire logic core_rx_er,
	output logic [1:0] rxd_o,
	output logic crs_dv_o,
	output logic rx_er_o,
	output logic data_oe,
	output logic ref_clk_o,
	output logic ref_clk_oe
);
	logic [RSP_LNK_W-1:0] ctl_l;
	logic rst_l_n;
	logic drive_l;
	logic mode25_l;
	logic iso_l;
	logic ref_oe_reg;
	logic alive_reg;

	rsp_sync3 #(.W(RSP_LNK_W)) u_ctl_sync (
		.clk(rmii_clk),
		.d(lif.ctl),
		.q(ctl_l)
	);
	assign rst_l_n = ctl_l[RSP_L_RST];
	assign drive_l = ctl_l[RSP_L_DRV];
	assign mode25_l = ctl_l[RSP_L_M25];
	assign iso_l = ctl_l[RSP_L_ISO];

	always_ff @(posedge rmii_clk) begin
		if (!rst_l_n) begin
			rxd_o <= 2'h0;
			crs_dv_o <= 1'b0;
			rx_er_o <= 1'b0;
		end else begin
			rxd_o <= core_rxd;
			crs_dv_o <= core_crs_dv;
			rx_er_o <= core_rx_er;
		end
	end

	// Isolate releases the data pins but leaves the MAC its clock
	always_ff @(posedge rmii_clk) begin
		if (!rst_l_n) begin
			data_oe <= 1'b0;
			ref_oe_reg <= 1'b0;
			alive_reg <= 1'b0;
		end else begin
			data_oe <= drive_l & ~iso_l;
			ref_oe_reg <= drive_l & mode25_l;
			alive_reg <= drive_l;
		end
	end
	assign lif.link_alive = alive_reg;
	// Clock passes straight through; a flop here would halve it
	assign ref_clk_o = rmii_clk;
	assign ref_clk_oe = ref_oe_reg;

	property p_ref_off_50m;
		@(posedge rmii_clk) disable iff (!rst_l_n)
		!mode25_l |=> !ref_clk_oe;
	endproperty
	a_ref_off_50m: assert property (p_ref_off_50m) else $error("ref clock driven in 50 MHz mode");

	property p_ref_on_25m;
		@(posedge rmii_clk) disable iff (!rst_l_n)
		(mode25_l && drive_l) [*2] |-> ref_clk_oe;
	endproperty
	a_ref_on_25m: assert property (p_ref_on_25m) else $error("ref clock not driven in 25 MHz mode");

	property p_pins_released;
		@(posedge rmii_clk) disable iff (!rst_l_n)
		!drive_l |=> !data_oe && !ref_clk_oe;
	endproperty
	a_pins_released: assert property (p_pins_released) else $error("pin driven before straps done");
endmodule : rsp_link
`default_nettype wire

/* logic/rsp_strap_pins.sv */
// Purpose: Strap capture at reset release and dual-role RMII pin control.
// Assumes: aresetn is synchronous; pins hold strap levels while it is low.
// Notes: Registers on AXI4-Lite; link pins run on rmii_clk.
//
// Notes on behaviour
// - At reset release, first address strap pin becomes address bit 0.
// - At reset release, second address strap pin becomes address bit 1.
// - Receive data bit 1 pin level at release becomes address bit 2.
// - Receive data bit 0 pin level at release becomes the duplex strap.
// - Carrier-sense/data-valid pin level at release becomes config strap bit 2.
// - Reference clock pin level at release becomes the address-zero broadcast option.
// - Receive error pin level at release becomes the isolate strap.
// - In 25 MHz mode the 50 MHz reference clock is driven to the MAC.
// - In 50 MHz mode the reference clock pin is never driven.
// - Interrupt pin either pulls low or releases to a pull-up.
// - Dual-role pins are inputs during reset; after it data pins drive unless isolated, the reference clock pin in 25 MHz mode only.
// - Duplex strap high selects half duplex, loaded into control bit 8.
// - Isolate strap high enables isolate, loaded into control bit 10.
// - Broadcast strap high makes address zero unique; low makes it broadcast.
`default_nettype none
module rsp_strap_pins import rsp_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic rmii_clk,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Strap-only pins
	input wire logic addr_strap_bit0_i,
	input wire logic addr_strap_bit1_i,
	// Dual-role pins
	input wire logic rx_data_bit1_i,
	output logic rx_data_bit1_o,
	output logic rx_data_bit1_oe,
	input wire logic rx_data_bit0_i,
	output logic rx_data_bit0_o,
	output logic rx_data_bit0_oe,
	input wire logic crs_dv_i,
	output logic crs_dv_o,
	output logic crs_dv_oe,
	input wire logic ref_clk_i,
	output logic ref_clk_o,
	output logic ref_clk_oe,
	input wire logic rx_error_out_i,
	output logic rx_error_out_o,
	output logic rx_error_out_oe,
	// Open-drain interrupt pin
	input wire logic irq_out_i,
	output logic irq_out_o,
	output logic irq_out_oe,
	// Core side
	input wire logic core_irq,
	input wire logic [1:0] core_rxd,
	input wire logic core_crs_dv,
	input wire logic core_rx_er,
	output logic [2:0] mgmt_station_addr,
	output logic cfg_strap_bit2,
	output logic addr_zero_bcast_disable,
	output logic addr_zero_bcast_en,
	output logic duplex_half,
	output logic isolate_en,
	output logic clk_mode_25m
);
	logic [RSP_NPIN-1:0] pin_raw;
	logic [RSP_NPIN-1:0] pin_filt;
	logic [RSP_NSTRAP-1:0] strap_reg;
	logic strap_done_reg;
	logic bcast_en_reg;
	logic capture;
	logic [15:0] ctrl_reg;
	logic mode25_reg;
	logic link_alive_a;
	logic wr_take;
	logic rd_take;
	logic wr_hit;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic [1:0] rxd_l;
	logic data_oe_l;

	rsp_link_if u_lif ();

	// Pins sampled through the synchroniser, straps and the irq line alike
	always_comb begin
		pin_raw = '0;
		pin_raw[RSP_S_A0] = addr_strap_bit0_i;
		pin_raw[RSP_S_A1] = addr_strap_bit1_i;
		pin_raw[RSP_S_A2] = rx_data_bit1_i;
		pin_raw[RSP_S_DUP] = rx_data_bit0_i;
		pin_raw[RSP_S_CFG2] = crs_dv_i;
		pin_raw[RSP_S_BCAST] = ref_clk_i;
		pin_raw[RSP_S_ISO] = rx_error_out_i;
		pin_raw[RSP_S_IRQ] = irq_out_i;
	end

	rsp_sync3 #(.W(RSP_NPIN)) u_pin_sync (
		.clk(aclk),
		.d(pin_raw),
		.q(pin_filt)
	);

	// First edge after release; pins are still inputs then
	assign capture = aresetn & ~strap_done_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_done_reg <= 1'b0;
		end else begin
			strap_done_reg <= 1'b1;
		end
	end

	// Loaded once per reset; later pin activity is ignored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strap_reg <= '0;
			bcast_en_reg <= 1'b0;
		end else if (capture) begin
			strap_reg <= pin_filt[RSP_NSTRAP-1:0];
			bcast_en_reg <= ~pin_filt[RSP_S_BCAST];
		end
	end

	assign mgmt_station_addr = strap_reg[RSP_S_A2:RSP_S_A0];
	assign cfg_strap_bit2 = strap_reg[RSP_S_CFG2];
	assign addr_zero_bcast_disable = strap_reg[RSP_S_BCAST];
	assign addr_zero_bcast_en = bcast_en_reg;

	// AXI4-Lite write channel: address and data are taken together
	assign wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg & strap_done_reg;
	assign s_axi_awready = wr_take;
	assign s_axi_wready = wr_take;
	assign wr_hit = (s_axi_awaddr[7:2] == RSP_OFF_CTRL[7:2])
		| (s_axi_awaddr[7:2] == RSP_OFF_CLK[7:2])
		| (s_axi_awaddr[7:2] == RSP_OFF_STRAP[7:2])
		| (s_axi_awaddr[7:2] == RSP_OFF_STAT[7:2]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RSP_RESP_OKAY;
		end else if (wr_take) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? RSP_RESP_OKAY : RSP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	// Straps seed the control bits; software may override afterwards
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= RSP_CTRL_RST;
		end else if (capture) begin
			ctrl_reg[RSP_CTRL_DUP] <= pin_filt[RSP_S_DUP];
			ctrl_reg[RSP_CTRL_ISO] <= pin_filt[RSP_S_ISO];
		end else if (wr_take && s_axi_wstrb[1]
			&& s_axi_awaddr[7:2] == RSP_OFF_CTRL[7:2]) begin
			ctrl_reg <= (ctrl_reg & ~RSP_CTRL_WMASK) | (s_axi_wdata[15:0] & RSP_CTRL_WMASK);
		end
	end

	// Clock mode follows board wiring; software tells the block which
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode25_reg <= RSP_MODE25_RST;
		end else if (wr_take && s_axi_wstrb[0]
			&& s_axi_awaddr[7:2] == RSP_OFF_CLK[7:2]) begin
			mode25_reg <= s_axi_wdata[0];
		end
	end

	assign duplex_half = ctrl_reg[RSP_CTRL_DUP];
	assign isolate_en = ctrl_reg[RSP_CTRL_ISO];
	assign clk_mode_25m = mode25_reg;

	// AXI4-Lite read channel
	assign rd_take = s_axi_arvalid & ~rvalid_reg & strap_done_reg;
	assign s_axi_arready = rd_take;

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr[7:2])
			RSP_OFF_CTRL[7:2]: begin
				rd_mux[15:0] = ctrl_reg;
			end
			RSP_OFF_STRAP[7:2]: begin
				rd_mux[RSP_NSTRAP-1:0] = strap_reg;
				rd_mux[RSP_STRAP_DONE] = strap_done_reg;
			end
			RSP_OFF_CLK[7:2]: begin
				rd_mux[0] = mode25_reg;
			end
			RSP_OFF_STAT[7:2]: begin
				rd_mux[0] = link_alive_a;
				rd_mux[1] = bcast_en_reg;
				rd_mux[2] = pin_filt[RSP_S_IRQ];
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= RSP_RESP_OKAY;
		end else if (rd_take) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_hit ? RSP_RESP_OKAY : RSP_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Open drain: never drive high, external pull-up gives the idle level
	assign irq_out_o = 1'b0;
	assign irq_out_oe = core_irq;

	// Levels to the link domain: aresetn as it arrives, the others each from a single flop
	always_comb begin
		u_lif.ctl = '0;
		u_lif.ctl[RSP_L_RST] = aresetn;
		u_lif.ctl[RSP_L_DRV] = strap_done_reg;
		u_lif.ctl[RSP_L_M25] = mode25_reg;
		u_lif.ctl[RSP_L_ISO] = ctrl_reg[RSP_CTRL_ISO];
	end

	rsp_sync3 #(.W(1)) u_alive_sync (
		.clk(aclk),
		.d(u_lif.link_alive),
		.q(link_alive_a)
	);

	rsp_link u_link (
		.rmii_clk(rmii_clk),
		.lif(u_lif.link),
		.core_rxd(core_rxd),
		.core_crs_dv(core_crs_dv),
		.core_rx_er(core_rx_er),
		.rxd_o(rxd_l),
		.crs_dv_o(crs_dv_o),
		.rx_er_o(rx_error_out_o),
		.data_oe(data_oe_l),
		.ref_clk_o(ref_clk_o),
		.ref_clk_oe(ref_clk_oe)
	);

	assign rx_data_bit1_o = rxd_l[1];
	assign rx_data_bit0_o = rxd_l[0];
	assign rx_data_bit1_oe = data_oe_l;
	assign rx_data_bit0_oe = data_oe_l;
	assign crs_dv_oe = data_oe_l;
	assign rx_error_out_oe = data_oe_l;

	property p_addr0;
		@(posedge aclk) disable iff (!aresetn)
		capture |=> mgmt_station_addr[0] == $past(pin_filt[RSP_S_A0]);
	endproperty
	a_addr0: assert property (p_addr0) else $error("address bit 0 not latched");

	property p_addr1;
		@(posedge aclk) disable iff (!aresetn)
		capture |-> ##1 (mgmt_station_addr[1] == $past(pin_filt[RSP_S_A1]));
	endproperty
	a_addr1: assert property (p_addr1) else $error("address bit 1 not latched");

	property p_addr2;
		@(posedge aclk) disable iff (!aresetn)
		capture |=> mgmt_station_addr[2] == $past(pin_filt[RSP_S_A2]);
	endproperty
	a_addr2: assert property (p_addr2) else $error("address bit 2 not latched");

	property p_duplex;
		@(posedge aclk) disable iff (!aresetn)
		capture |=> (strap_reg[RSP_S_DUP] == $past(pin_filt[RSP_S_DUP]))
			&& (duplex_half == strap_reg[RSP_S_DUP]);
	endproperty
	a_duplex: assert property (p_duplex) else $error("duplex strap not applied");

	property p_cfg2;
		@(posedge aclk) disable iff (!aresetn)
		capture |=> cfg_strap_bit2 == $past(crs_dv_i, 4);
	endproperty
	a_cfg2: assert property (p_cfg2) else $error("config strap bit 2 not latched");

	property p_bcast;
		@(posedge aclk) disable iff (!aresetn)
		strap_done_reg |-> addr_zero_bcast_en != addr_zero_bcast_disable;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast option inconsistent");

	property p_isolate;
		@(posedge aclk) disable iff (!aresetn)
		capture |=> isolate_en == $past(pin_filt[RSP_S_ISO]);
	endproperty
	a_isolate: assert property (p_isolate) else $error("isolate strap not applied");

	property p_hold;
		@(posedge aclk) disable iff (!aresetn)
		strap_done_reg |=> $stable(strap_reg) && $stable(bcast_en_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("latched strap changed");

	property p_irq_od;
		@(posedge aclk) disable iff (!aresetn)
		$rose(core_irq) |-> irq_out_oe && !irq_out_o;
	endproperty
	a_irq_od: assert property (p_irq_od) else $error("interrupt pin driven high");
endmodule : rsp_strap_pins
`default_nettype wire

/* logic/rsp_strap_pins_unused_guard.sv */
`default_nettype none
`default_nettype wire

/* verification/rsp_mac_model.sv */
// Purpose: Far-side MAC model: strap resistors on the pins and RMII receive capture.
// Assumes: pull holds the board's strap levels; irq line has a pull-up.
// Notes: A released line settles to its resistor level, never to its last value.
`default_nettype none
module rsp_mac_model (
	input wire logic rmii_clk,
	input wire logic [6:0] pull,
	input wire logic [5:0] pin_o,
	input wire logic [5:0] pin_oe,
	output logic [5:0] pin_i,
	output logic [3:0] rx_seen
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [5:0] pull_lvl;
	assign pull_lvl = {1'b1, pull[6:2]};
	// An enable not yet settled after power-up leaves the line to its resistor
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			pin_i[k] = (pin_oe[k] === 1'b1) ? pin_o[k] : pull_lvl[k];
		end
	end
	// MAC samples on the same reference clock the device drives data on
	always_ff @(posedge rmii_clk) rx_seen <= {pin_i[2], pin_i[4], pin_i[0], pin_i[1]};
endmodule : rsp_mac_model
`default_nettype wire

/* verification/tb_rsp_strap_pins.sv */
// Purpose: Self-checking bench for strap capture, pin roles and registers.
// Assumes: AXI4-Lite master here; MAC side in rsp_mac_model.
// Notes: Resets after the first run 100 cycles so the link domain settles before release; the first runs 16.
`default_nettype none
module tb_rsp_strap_pins import rsp_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, rmii_clk, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, rx_seen, v;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, core_rxd, rsp, m;
	logic rx_data_bit1_o, rx_data_bit1_oe, rx_data_bit0_o, rx_data_bit0_oe, crs_dv_o, crs_dv_oe;
	logic ref_clk_o, ref_clk_oe, rx_error_out_o, rx_error_out_oe, irq_out_o, irq_out_oe;
	logic core_irq, core_crs_dv, core_rx_er, cfg_strap_bit2, addr_zero_bcast_disable;
	logic addr_zero_bcast_en, duplex_half, isolate_en, clk_mode_25m;
	logic [2:0] mgmt_station_addr;
	logic [6:0] pull, s;
	logic [5:0] pin_i;
	int failures, checks, seed;
	wire logic [5:0] pin_o = {irq_out_o, rx_error_out_o, ref_clk_o, crs_dv_o, rx_data_bit0_o,
		rx_data_bit1_o};
	wire logic [5:0] pin_oe = {irq_out_oe, rx_error_out_oe, ref_clk_oe, crs_dv_oe, rx_data_bit0_oe,
		rx_data_bit1_oe};
	rsp_strap_pins u_rsp_strap_pins (.aclk, .aresetn, .rmii_clk, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .addr_strap_bit0_i(pull[0]),
		.addr_strap_bit1_i(pull[1]), .rx_data_bit1_i(pin_i[0]), .rx_data_bit0_i(pin_i[1]),
		.crs_dv_i(pin_i[2]), .ref_clk_i(pin_i[3]), .rx_error_out_i(pin_i[4]), .irq_out_i(pin_i[5]),
		.rx_data_bit1_o, .rx_data_bit1_oe, .rx_data_bit0_o, .rx_data_bit0_oe, .crs_dv_o, .crs_dv_oe,
		.ref_clk_o, .ref_clk_oe, .rx_error_out_o, .rx_error_out_oe, .irq_out_o, .irq_out_oe,
		.core_irq, .core_rxd, .core_crs_dv, .core_rx_er, .mgmt_station_addr, .cfg_strap_bit2,
		.addr_zero_bcast_disable, .addr_zero_bcast_en, .duplex_half, .isolate_en, .clk_mode_25m);
	rsp_mac_model u_rsp_mac_model (.rmii_clk, .pull, .pin_o, .pin_oe, .pin_i, .rx_seen);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Odd start offset keeps the link clock out of phase with aclk
	initial begin
		rmii_clk = 1'b0;
		#37;
		forever #80 rmii_clk = ~rmii_clk;
	end
	function automatic logic [31:0] exp_strap(input logic [6:0] t);
		return {23'h0, 1'b1, 1'b0, t};
	endfunction : exp_strap
	function automatic logic [31:0] exp_ctrl(input logic [6:0] t);
		logic [31:0] e;
		e = 32'h0;
		e[RSP_CTRL_DUP] = t[3];
		e[RSP_CTRL_ISO] = t[6];
		return e;
	endfunction : exp_ctrl
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task test_done;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// Waits without limit; only the watchdog ends a hung transfer
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		chk("axi_wr_taken", {s_axi_awvalid, s_axi_wvalid}, 32'h0);
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk("axi_rd_taken", s_axi_arvalid, 32'h0);
	endtask : axi_rd
	task wait_lvl(input int w, input logic e);
		int k;
		for (k = 0; k < 300 && (w ? ref_clk_oe : rx_data_bit0_oe) !== e; k++) @(posedge aclk);
		if (w) chk("ref_clk_oe", ref_clk_oe, e);
		else chk("data_oe", {rx_data_bit1_oe, rx_data_bit0_oe, crs_dv_oe, rx_error_out_oe}, {4{e}});
	endtask : wait_lvl
	task do_reset(input logic [6:0] t, input int n);
		@(posedge aclk);
		pull <= t;
		aresetn <= 1'b0;
		repeat (n) @(posedge aclk);
		chk("oe_in_reset", pin_oe[4:0], 32'h0);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask : do_reset
	task check_straps(input logic [6:0] t);
		chk("addr", mgmt_station_addr, t[2:0]);
		chk("cfg2", cfg_strap_bit2, t[4]);
		chk("bcast_dis", addr_zero_bcast_disable, t[5]);
		chk("bcast_en", addr_zero_bcast_en, !t[5]);
		chk("half_dup", duplex_half, t[3]);
		chk("isolate", isolate_en, t[6]);
		axi_rd(RSP_OFF_STRAP, rd, rsp);
		chk("strap_reg", rd, exp_strap(t));
		axi_rd(RSP_OFF_CTRL, rd, rsp);
		chk("ctrl_reg", rd, exp_ctrl(t));
	endtask : check_straps
	task ref_phase(input logic hi, input logic lo);
		@(posedge rmii_clk);
		#1;
		chk("ref_pin_hi", pin_i[3], hi);
		@(negedge rmii_clk);
		#1;
		chk("ref_pin_lo", pin_i[3], lo);
	endtask : ref_phase
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
			s_axi_arvalid, s_axi_rready, core_irq, core_rxd, core_crs_dv, core_rx_er, aresetn} = '0;
		s_axi_wstrb = 4'hF;
		pull = 7'h2B;
		seed = 32'h5194;
		failures = 0;
		checks = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		check_straps(7'h2B);
		$display("test first_reset done");
		for (int i = 0; i < 6; i++) begin
			s = (i == 0) ? 7'h7F : (i == 1) ? 7'h00 : 7'($random(seed));
			do_reset(s, 100);
			check_straps(s);
			wait_lvl(0, !s[6]);
			wait_lvl(1, 1'b1);
			pull <= ~s;
			repeat (20) @(posedge aclk);
			check_straps(s);
		end
		$display("test strap_sweep done");
		s = 7'h15;
		do_reset(s, 100);
		wait_lvl(0, 1'b1);
		for (int i = 0; i < 16; i++) begin
			v = 4'($random(seed));
			@(posedge rmii_clk);
			{core_crs_dv, core_rx_er, core_rxd} <= v;
			repeat (2) @(posedge rmii_clk);
			@(negedge rmii_clk);
			chk("rx_pins", rx_seen, v);
		end
		$display("test rx_stream done");
		wait_lvl(1, 1'b1);
		axi_rd(RSP_OFF_CLK, rd, rsp);
		chk("clkcfg_rst", rd, 32'h1);
		ref_phase(1'b1, 1'b0);
		axi_wr(RSP_OFF_CLK, 32'h0, rsp);
		chk("clkcfg_wr", rsp, RSP_RESP_OKAY);
		chk("clk_mode", clk_mode_25m, 1'b0);
		wait_lvl(1, 1'b0);
		ref_phase(s[5], s[5]);
		axi_wr(RSP_OFF_CLK, 32'h1, rsp);
		wait_lvl(1, 1'b1);
		$display("test clock_mode done");
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			rd = 32'($random(seed)) & ~32'h0000_0500 | {21'h0, m[1], 1'b0, m[0], 8'h00};
			axi_wr(RSP_OFF_CTRL, rd, rsp);
			chk("ctrl_wr", rsp, RSP_RESP_OKAY);
			axi_rd(RSP_OFF_CTRL, rd, rsp);
			chk("ctrl_rd", rd, {21'h0, m[1], 1'b0, m[0], 8'h00});
			chk("ctrl_out", {isolate_en, duplex_half}, m);
			wait_lvl(0, !m[1]);
		end
		// Control bits sit in byte 1; a write without that lane leaves them alone
		s_axi_wstrb <= 4'h1;
		axi_wr(RSP_OFF_CTRL, 32'h0, rsp);
		s_axi_wstrb <= 4'hF;
		axi_rd(RSP_OFF_CTRL, rd, rsp);
		chk("ctrl_wstrb", rd, 32'h0000_0500);
		for (int j = 0; j < 2; j++) begin
			axi_wr(j ? 8'hFC : 8'h10, 32'hFFFF_FFFF, rsp);
			chk("unmapped_wr", rsp, RSP_RESP_SLVERR);
			axi_rd(j ? 8'hFC : 8'h10, rd, rsp);
			chk("unmapped_rd", rd, 32'h0);
			chk("unmapped_rresp", rsp, RSP_RESP_SLVERR);
		end
		axi_wr(RSP_OFF_STRAP, 32'h0, rsp);
		axi_rd(RSP_OFF_STRAP, rd, rsp);
		chk("strap_ro", rd, exp_strap(s));
		$display("test registers done");
		for (int i = 0; i < 2; i++) begin
			@(posedge aclk);
			core_irq <= 1'(i);
			@(negedge aclk);
			chk("irq_pin", {irq_out_oe, irq_out_o, pin_i[5]}, {1'(i), 1'b0, !1'(i)});
			repeat (8) @(posedge aclk);
			axi_rd(RSP_OFF_STAT, rd, rsp);
			chk("stat", rd[2:0], {!1'(i), !s[5], 1'b1});
		end
		$display("test irq done");
		test_done();
	end
	initial begin
		#500000;
		failures++;
		test_done();
	end
endmodule : tb_rsp_strap_pins
`default_nettype wire
